// *** logic/tsam_consts.vh ***
`ifndef TSAM_CONSTS_VH
`define TSAM_CONSTS_VH
// register byte offsets
`define TSAM_OFF_OVERSHIFT 5'h00
`define TSAM_OFF_RANGE 5'h04
`define TSAM_OFF_FEEDCLAMP 5'h08
`define TSAM_OFF_FLAGS 5'h0C
`define TSAM_OFF_INTSTAT 5'h10
`define TSAM_OFF_INTCLR 5'h14
`define TSAM_OFF_INTEN 5'h18
// reset values of the settings, units of 0.001 mm
`define TSAM_RST_OVERSHIFT 16'h04B0
`define TSAM_RST_RANGE 16'h03E8
`define TSAM_RST_FEEDCLAMP 16'h0000
// flags register fields
`define TSAM_FLG_FAULT 0
`define TSAM_FLG_OOR 1
`define TSAM_FLG_OVS 2
`define TSAM_FLG_RNG 3
// interrupt event bits
`define TSAM_EV_OVS 0
`define TSAM_EV_RNG 1
`define TSAM_EV_OOR 2
`define TSAM_EV_W 3
// pin input order in the synchroniser
`define TSAM_PIN_APPR 0
`define TSAM_PIN_CHK 1
`define TSAM_PIN_RST 2
`define TSAM_PIN_W 3
// bus responses
`define TSAM_RESP_OKAY 2'h0
`define TSAM_RESP_SLVERR 2'h2
`endif

// *** logic/tsam_monitor.v ***
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "tsam_consts.vh"

// Contract
// - during approach, too-close nozzle halts motion and sets fault flag
// - over-shift trip level is a programmable setting chosen by configurer
// - check-only off and abs shift at or above limit: stop, set fault
// - check-only on: no range alarm, status flag high while abs shift at limit
// - range limit comes from a programmable setting
// - fault flag set on over-shift, or range-over with check-only off
// - fault flag cleared only by operator reset, otherwise latched
// - status flag forced low whenever check-only select is low
module tsam_monitor #(
  parameter SHIFT_W = 16
)(
  input wire clk,
  input wire rst_n,
  input wire clkEn,
  input wire signed [SHIFT_W-1:0] shiftValue,
  input wire approachActive,
  input wire checkOnlySelect,
  input wire operatorReset,
  output reg tracingFaultFlag,
  output reg outOfRangeStatus,
  output reg stopMotion,
  output reg irq,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // byte-lane merge of a 16-bit setting
  function [15:0] mergeBytes;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      mergeBytes[7:0] = strb[0] ? data[7:0] : old[7:0];
      mergeBytes[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  // magnitude of the signed shift, one bit wider to hold the most negative
  function [SHIFT_W:0] absShift;
    input signed [SHIFT_W-1:0] v;
    begin
      if (v[SHIFT_W-1])
        absShift = {1'b0, ~v} + {{SHIFT_W{1'b0}}, 1'b1};
      else
        absShift = {1'b0, v};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  reg rstMeta_q;
  reg rstSync_q;

  // two-stage release of the asynchronous reset
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and input registers

  wire [`TSAM_PIN_W-1:0] pinRaw;
  reg [`TSAM_PIN_W-1:0] pinS1_q;
  reg [`TSAM_PIN_W-1:0] pinS2_q;
  reg [`TSAM_PIN_W-1:0] pinS3_q;
  reg [`TSAM_PIN_W-1:0] pinStable_q;
  reg [`TSAM_PIN_W-1:0] pinStable_d;
  reg signed [SHIFT_W-1:0] shift_q;
  integer i;

  assign pinRaw = {operatorReset, checkOnlySelect, approachActive};

  // a pin changes only once stages two and three agree
  always @*
  begin
    for (i = 0; i < `TSAM_PIN_W; i = i + 1)
      pinStable_d[i] = (pinS2_q[i] == pinS3_q[i]) ? pinS3_q[i] : pinStable_q[i];
  end

  // four flops per pin (three stages and the stable value), plus the registered shift sample
  always @(posedge clk or negedge rstSync_q)
  begin
    if (!rstSync_q)
    begin
      pinS1_q <= {`TSAM_PIN_W{1'b0}};
      pinS2_q <= {`TSAM_PIN_W{1'b0}};
      pinS3_q <= {`TSAM_PIN_W{1'b0}};
      pinStable_q <= {`TSAM_PIN_W{1'b0}};
      shift_q <= {SHIFT_W{1'b0}};
    end
    else if (clkEn)
    begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinStable_q <= pinStable_d;
      shift_q <= shiftValue;
    end
  end

  wire inApproach = pinStable_q[`TSAM_PIN_APPR];
  wire checkOnly = pinStable_q[`TSAM_PIN_CHK];
  // operator reset acts on its press edge
  wire resetPress = pinStable_d[`TSAM_PIN_RST] & ~pinStable_q[`TSAM_PIN_RST];

  ////////////////////////////////////////////////////////////////////////////
  // settings registers

  reg [15:0] overShiftLimit_q;
  reg [15:0] rangeLimitValue_q;
  reg [15:0] feedClamp_q;
  reg [`TSAM_EV_W-1:0] intStat_q;
  reg [`TSAM_EV_W-1:0] intEn_q;

  ////////////////////////////////////////////////////////////////////////////
  // shift checks

  wire [SHIFT_W:0] shiftMag = absShift(shift_q);
  // closer than allowed: positive shift beyond the trip level
  wire overShiftHit = inApproach & ~shift_q[SHIFT_W-1] &
    ({1'b0, shift_q} > {{(SHIFT_W+1-16){1'b0}}, overShiftLimit_q});
  wire rangeHit = shiftMag >= {{(SHIFT_W+1-16){1'b0}}, rangeLimitValue_q};
  wire rangeAlarm = rangeHit & ~checkOnly;
  wire oor_d = rangeHit & checkOnly;
  wire faultSet = overShiftHit | rangeAlarm;

  reg ovsLatch_q;
  reg rngLatch_q;
  wire fault_d = faultSet | (tracingFaultFlag & ~resetPress);

  // latched fault, motion stop and level status, updated each cycle that clkEn is high
  always @(posedge clk or negedge rstSync_q)
  begin
    if (!rstSync_q)
    begin
      tracingFaultFlag <= 1'b0;
      stopMotion <= 1'b0;
      outOfRangeStatus <= 1'b0;
      ovsLatch_q <= 1'b0;
      rngLatch_q <= 1'b0;
    end
    else if (clkEn)
    begin
      tracingFaultFlag <= fault_d;
      stopMotion <= fault_d;
      outOfRangeStatus <= oor_d;
      ovsLatch_q <= overShiftHit | (ovsLatch_q & ~resetPress);
      rngLatch_q <= rangeAlarm | (rngLatch_q & ~resetPress);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus write path

  reg [4:0] awAddr_q;
  reg awHeld_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg wHeld_q;
  wire doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
  wire wrMapped = (awAddr_q[4:2] <= 3'h6) & (awAddr_q != `TSAM_OFF_FLAGS) &
    (awAddr_q != `TSAM_OFF_INTSTAT) & (awAddr_q[1:0] == 2'h0);
  wire [`TSAM_EV_W-1:0] events;
  wire [`TSAM_EV_W-1:0] clrMask;

  assign events = {oor_d & ~outOfRangeStatus, rangeAlarm & ~rngLatch_q,
    overShiftHit & ~ovsLatch_q};
  assign clrMask = (doWrite && awAddr_q == `TSAM_OFF_INTCLR && wStrb_q[0]) ?
    wData_q[`TSAM_EV_W-1:0] : {`TSAM_EV_W{1'b0}};

  // address and data are taken in either order, response follows both
  always @(posedge clk or negedge rstSync_q)
  begin
    if (!rstSync_q)
    begin
      awAddr_q <= 5'h00;
      awHeld_q <= 1'b0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      wHeld_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TSAM_RESP_OKAY;
      overShiftLimit_q <= `TSAM_RST_OVERSHIFT;
      rangeLimitValue_q <= `TSAM_RST_RANGE;
      feedClamp_q <= `TSAM_RST_FEEDCLAMP;
      intEn_q <= {`TSAM_EV_W{1'b0}};
      intStat_q <= {`TSAM_EV_W{1'b0}};
      irq <= 1'b0;
    end
    else if (clkEn)
    begin
      s_axi_awready <= ~awHeld_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~wHeld_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_q <= s_axi_awaddr;
        awHeld_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHeld_q <= 1'b1;
      end
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `TSAM_RESP_OKAY : `TSAM_RESP_SLVERR;
        case (awAddr_q)
          `TSAM_OFF_OVERSHIFT: overShiftLimit_q <= mergeBytes(overShiftLimit_q,
            wData_q, wStrb_q);
          `TSAM_OFF_RANGE: rangeLimitValue_q <= mergeBytes(rangeLimitValue_q,
            wData_q, wStrb_q);
          `TSAM_OFF_FEEDCLAMP: feedClamp_q <= mergeBytes(feedClamp_q, wData_q,
            wStrb_q);
          `TSAM_OFF_INTEN: if (wStrb_q[0]) intEn_q <= wData_q[`TSAM_EV_W-1:0];
          default: ;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // sticky events, a new event beats a clear in the same cycle
      intStat_q <= (intStat_q & ~clrMask) | events;
      irq <= |(((intStat_q & ~clrMask) | events) & intEn_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus read path

  reg [31:0] rdMux;

  // read data selection
  always @*
  begin
    rdMux = 32'h00000000;
    case (s_axi_araddr)
      `TSAM_OFF_OVERSHIFT: rdMux[15:0] = overShiftLimit_q;
      `TSAM_OFF_RANGE: rdMux[15:0] = rangeLimitValue_q;
      `TSAM_OFF_FEEDCLAMP: rdMux[15:0] = feedClamp_q;
      `TSAM_OFF_FLAGS:
      begin
        rdMux[`TSAM_FLG_FAULT] = tracingFaultFlag;
        rdMux[`TSAM_FLG_OOR] = outOfRangeStatus;
        rdMux[`TSAM_FLG_OVS] = ovsLatch_q;
        rdMux[`TSAM_FLG_RNG] = rngLatch_q;
      end
      `TSAM_OFF_INTSTAT: rdMux[`TSAM_EV_W-1:0] = intStat_q;
      `TSAM_OFF_INTEN: rdMux[`TSAM_EV_W-1:0] = intEn_q;
      default: rdMux = 32'h00000000;
    endcase
  end

  wire rdMapped = (s_axi_araddr[4:2] <= 3'h6) & (s_axi_araddr[1:0] == 2'h0) &
    (s_axi_araddr != `TSAM_OFF_INTCLR);

  // one read at a time, data one cycle after the address is taken
  always @(posedge clk or negedge rstSync_q)
  begin
    if (!rstSync_q)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TSAM_RESP_OKAY;
    end
    else if (clkEn)
    begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdMapped ? `TSAM_RESP_OKAY : `TSAM_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // tsam_monitor

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "tsam_consts.vh"
module tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg signed [15:0] shiftValue = 16'h0000;
  reg wantAppr = 1'b0, wantChk = 1'b0, clearReq = 1'b0;
  reg [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  reg [31:0] s_axi_wdata = 32'h00000000, lim, ovs;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire tracingFaultFlag, outOfRangeStatus, stopMotion, approachActive, checkOnlySelect;
  wire operatorReset;
  reg clkEn = 1'b1;
  integer mismatches = 0, comparisons = 0, cycles = 0;
  logic [1:0] bq[$];
  logic [33:0] rq[$];

  tsam_monitor i_dut (.*);
  tsam_ladder i_plc (.clk(clk), .wantAppr(wantAppr), .wantChk(wantChk), .clearReq(clearReq),
    .retracted(shiftValue <= 16'sh0000), .approachActive(approachActive),
    .checkOnlySelect(checkOnlySelect), .operatorReset(operatorReset));

  always #2.5 clk = ~clk;

  task chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic b;
    b = 1'b1;
    bq.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (b)
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) b = 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  // rready comes up after a random delay and stays up until rvalid is seen
  task rd(input logic [4:0] a, input logic [33:0] e);
    logic b;
    int dl;
    b = 1'b1;
    dl = $urandom % 4;
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (dl == 0);
    while (b)
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) b = 1'b0;
      else if (dl > 0)
      begin
        dl = dl - 1;
        if (dl == 0) s_axi_rready <= 1'b1;
      end
    end
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // pin sync and flag update fit well inside eight cycles
  task settle;
    repeat (8) @(posedge clk);
  endtask

  task pins(input logic [2:0] e);
    chk("fault oor irq", {31'h0, tracingFaultFlag, outOfRangeStatus, irq}, {31'h0, e});
  endtask

  task clr;
    clearReq <= 1'b1;
    repeat (10) @(posedge clk);
    clearReq <= 1'b0;
    settle;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // compare each bus answer with the oldest note
  always @(posedge clk)
  begin
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (s_axi_rvalid && s_axi_rready) chk("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end

  // cycle ceiling against hangs
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end

  initial
  begin
    lim = $urandom(87);
    lim = 32'd200 + $urandom % 500;
    ovs = lim + 32'd100 + $urandom % 500;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`TSAM_OFF_OVERSHIFT, {18'h0, `TSAM_RST_OVERSHIFT});
    rd(`TSAM_OFF_RANGE, {18'h0, `TSAM_RST_RANGE});
    rd(`TSAM_OFF_INTCLR, {`TSAM_RESP_SLVERR, 32'h0});
    rd(5'h1C, {`TSAM_RESP_SLVERR, 32'h0});
    wr(`TSAM_OFF_FLAGS, 32'hF, `TSAM_RESP_SLVERR);
    wr(`TSAM_OFF_INTSTAT, 32'h7, `TSAM_RESP_SLVERR);
    rd(`TSAM_OFF_FLAGS, 34'h0);
    rd(`TSAM_OFF_INTSTAT, 34'h0);
    $display("test reset values done");
    wr(`TSAM_OFF_RANGE, lim, `TSAM_RESP_OKAY);
    wr(`TSAM_OFF_OVERSHIFT, ovs, `TSAM_RESP_OKAY);
    wr(`TSAM_OFF_FEEDCLAMP, 32'h400, `TSAM_RESP_OKAY); // 4 x 2048 over 8 mm
    rd(`TSAM_OFF_FEEDCLAMP, 34'h400);
    s_axi_wstrb <= 4'h2;
    wr(`TSAM_OFF_FEEDCLAMP, 32'hFFFF, `TSAM_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(`TSAM_OFF_FEEDCLAMP, 34'hFF00);
    wr(`TSAM_OFF_INTEN, 32'h3, `TSAM_RESP_OKAY);
    shiftValue <= lim[15:0] - 16'h1;
    settle;
    pins(3'b000);
    shiftValue <= -lim[15:0];
    settle;
    pins(3'b101);
    rd(`TSAM_OFF_FLAGS, 34'h9);
    shiftValue <= 16'h0;
    settle;
    pins(3'b101);
    rd(`TSAM_OFF_INTSTAT, 34'h2);
    clr;
    pins(3'b001);
    wr(`TSAM_OFF_INTCLR, 32'h7, `TSAM_RESP_OKAY);
    settle;
    pins(3'b000);
    $display("test range alarm done");
    wantChk <= 1'b1;
    shiftValue <= lim[15:0] - 16'h1;
    settle;
    pins(3'b000);
    clkEn <= 1'b0;
    shiftValue <= 16'h7FFF;
    settle;
    pins(3'b000);
    clkEn <= 1'b1;
    settle;
    pins(3'b010);
    rd(`TSAM_OFF_INTSTAT, 34'h4);
    shiftValue <= lim[15:0] - 16'h1;
    settle;
    pins(3'b000);
    shiftValue <= 16'h7FFF;
    settle;
    wantChk <= 1'b0;
    settle;
    pins(3'b101);
    shiftValue <= 16'h0;
    clr;
    wr(`TSAM_OFF_INTCLR, 32'h7, `TSAM_RESP_OKAY);
    settle;
    pins(3'b000);
    $display("test check-only done");
    wantChk <= 1'b1;
    settle;
    shiftValue <= 16'h7FFF;
    settle;
    pins(3'b010);
    wantAppr <= 1'b1;
    shiftValue <= ovs[15:0];
    settle;
    pins(3'b010);
    shiftValue <= 16'h7FFF;
    settle;
    pins(3'b111);
    rd(`TSAM_OFF_FLAGS, 34'h7);
    clr;
    pins(3'b111);
    shiftValue <= 16'h0;
    wantAppr <= 1'b0;
    clr;
    pins(3'b001);
    $display("test over-shift done");
    complete_run;
  end
endmodule // tb

// *** tb/tsam_flag_monitor.sv ***
`timescale 1ns/1ps
// flag and bus relations at the monitor ports
module tsam_flag_monitor #(
  parameter SHIFT_W = 16
)(
  input wire clk,
  input wire rst_n,
  input wire clkEn,
  input wire signed [SHIFT_W-1:0] shiftValue,
  input wire approachActive,
  input wire checkOnlySelect,
  input wire operatorReset,
  input wire tracingFaultFlag,
  input wire outOfRangeStatus,
  input wire stopMotion,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  // a frozen clock enable holds every flag, so the relations pause with it
  default disable iff (!rst_n || !clkEn);
  // settled pins with a full-scale shift held
  sequence hitOff; (!checkOnlySelect && shiftValue == 16'sh7FFF) [*6]; endsequence
  sequence hitOn; (checkOnlySelect && !approachActive && shiftValue == 16'sh7FFF) [*6]; endsequence
  sequence ovsOn; (checkOnlySelect && approachActive && shiftValue == 16'sh7FFF) [*6]; endsequence
  sequence noPress; !operatorReset [*8]; endsequence
  a_stop_mirror: assert property (stopMotion == tracingFaultFlag)
    else $error("stop differs from fault flag");
  a_range_alarm: assert property (hitOff |-> tracingFaultFlag)
    else $error("range hit without fault");
  a_check_status: assert property (hitOn |-> outOfRangeStatus)
    else $error("range hit without status");
  a_check_quiet: assert property ((checkOnlySelect && !approachActive) [*6] ##0
    !tracingFaultFlag |=> !tracingFaultFlag)
    else $error("fault raised in check-only mode");
  a_ovs_trip: assert property (ovsOn |-> tracingFaultFlag)
    else $error("over-shift without fault");
  a_oor_low: assert property (!checkOnlySelect [*6] |-> !outOfRangeStatus)
    else $error("status high with check-only off");
  a_fault_latched: assert property (noPress ##0 tracingFaultFlag |=> tracingFaultFlag)
    else $error("fault dropped without reset press");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule // tsam_flag_monitor

bind tsam_monitor tsam_flag_monitor #(.SHIFT_W(SHIFT_W)) i_chk (.*);

// *** tb/tsam_ladder.sv ***
`timescale 1ns/1ps
// ladder controller pins and operator reset button
module tsam_ladder (
  input wire clk,
  input wire wantAppr,
  input wire wantChk,
  input wire clearReq,
  input wire retracted,
  output reg approachActive = 1'b0,
  output reg checkOnlySelect = 1'b0,
  output reg operatorReset = 1'b0
);
  reg [2:0] pressCnt_q = 3'h0;
  // button held four cycles, pressed only with the nozzle up
  always @(posedge clk)
  begin
    approachActive <= wantAppr;
    checkOnlySelect <= wantChk;
    operatorReset <= pressCnt_q > 3'h3;
    if (pressCnt_q != 3'h0)
      pressCnt_q <= pressCnt_q - 3'h1;
    else if (clearReq && retracted)
      pressCnt_q <= 3'h7;
  end
endmodule // tsam_ladder
